// ---- hw/sacp_pkg.sv ----
// Package with constants and carrier types for the conversion bus port
package sacp_pkg;

    localparam int unsigned CLK_HZ             = 40_000_000;
    localparam int unsigned CLK_MHZ            = CLK_HZ / 1_000_000;
    localparam int unsigned RESULT_W           = 14;
    // Timing in nanoseconds, then the same times rounded up to core clock cycles
    localparam int unsigned POWERUP_NS         = 10_000;
    localparam int unsigned CONV_NS            = 7_800;
    localparam int unsigned HOLD_NS            = 1_500;
    localparam int unsigned TRACK_LEAD_NS      = 2_000;
    localparam int unsigned POWERUP_CYC        = (POWERUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CONV_CYC           = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HOLD_CYC           = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TRACK_LEAD_CYC     = (TRACK_LEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W              = 9;
    localparam logic [13:0] RESULT_RESET       = 14'h0000;
    localparam logic [13:0] SIGN_FLIP          = 14'h2000;

    typedef enum logic [1:0] {
        SACP_POWERUP,
        SACP_IDLE,
        SACP_HOLD,
        SACP_TRACK
    } sacp_state_t;

    typedef struct packed {
        logic [13:0] data;
        logic        oe;
    } sacp_bus_t;

endpackage

// ---- hw/sacp_buf.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sacp_buf (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [13:0] in_data,
    input  wire logic        in_valid,
    output var  logic        in_ready,
    output var  logic [13:0] out_data,
    output var  logic        out_valid,
    input  wire logic        out_ready
);
    logic [13:0] mem_reg [2];
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic [1:0]  count_reg;
    logic        push;
    logic        pop;

    assign push      = in_valid && (count_reg != 2'h2);
    assign pop       = out_ready && (count_reg != 2'h0);
    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// ---- hw/sacp_port.sv ----
// Conversion control and parallel read port of the sampling converter
`timescale 1ns/100ps
`default_nettype none
module sacp_port
    import sacp_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  start_convert_n,
    input  wire logic                  chip_select_n,
    input  wire logic                  read_enable_n,
    input  wire logic                  done_output_enable_n,
    input  wire logic                  bipolar_offset_strap,
    input  wire logic [13:0]           sample_code,
    output logic                       done_out,
    output logic                       done_oe,
    output sacp_pkg::sacp_bus_t        result_bits,
    output logic                       track_mode,
    output logic                       core_ready
);
    import sacp_pkg::*;

    sacp_state_t       state_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic              start_q_reg;
    logic              strap_reg;
    logic              start_fall;
    logic [13:0]       held_reg;
    logic [13:0]       coded;
    logic              buf_valid;
    logic              buf_in_ready;
    logic [13:0]       buf_data;
    logic              done_reg;
    logic              done_oe_reg;
    logic              track_reg;
    logic [13:0]       data_reg;
    logic              data_oe_reg;
    logic              read_start;
    logic              rd_q_reg;
    logic              buf_out_valid;
    logic              core_ready_reg;
    logic [CNT_W-1:0]  track_cnt_reg;

    assign start_fall = start_q_reg && !start_convert_n;
    assign read_start = rd_q_reg && !(chip_select_n || read_enable_n);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            start_q_reg <= 1'b1;
            rd_q_reg    <= 1'b1;
        end else begin
            start_q_reg <= start_convert_n;
            rd_q_reg    <= chip_select_n || read_enable_n;
        end
    end

    always_ff @(posedge core_clk) begin
        if (state_reg == SACP_POWERUP) begin
            strap_reg <= bipolar_offset_strap;
        end
    end

    // bipolar midscale flip to twos complement
    assign coded = strap_reg ? (held_reg ^ SIGN_FLIP) : held_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= SACP_POWERUP;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                SACP_POWERUP: begin
                    if (cnt_reg == CNT_W'(POWERUP_CYC - 1)) begin
                        state_reg <= SACP_IDLE;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                SACP_IDLE: begin
                    if (start_fall && buf_in_ready) begin
                        state_reg <= SACP_HOLD;
                        cnt_reg   <= '0;
                    end
                end
                SACP_HOLD: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CNT_W'(HOLD_CYC - 1)) begin
                        state_reg <= SACP_TRACK;
                    end
                end
                SACP_TRACK: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CNT_W'(CONV_CYC - 1)) begin
                        state_reg <= SACP_IDLE;
                        cnt_reg   <= '0;
                    end
                end
                default: begin
                    state_reg <= SACP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            held_reg <= RESULT_RESET;
        end else if (state_reg == SACP_IDLE && start_fall && buf_in_ready) begin
            held_reg <= sample_code;
        end
    end

    assign buf_valid = (state_reg == SACP_TRACK) && (cnt_reg == CNT_W'(CONV_CYC - 1));

    sacp_buf u_buf (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_data   (coded),
        .in_valid  (buf_valid),
        .in_ready  (buf_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_out_valid),
        .out_ready (read_start)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            done_reg  <= 1'b1;
            track_reg <= 1'b1;
        end else begin
            done_reg  <= (state_reg == SACP_IDLE || state_reg == SACP_POWERUP || buf_valid) &&
                         !(state_reg == SACP_IDLE && start_fall && buf_in_ready);
            track_reg <= !(state_reg == SACP_HOLD && cnt_reg != CNT_W'(HOLD_CYC - 1)) &&
                         !(state_reg == SACP_IDLE && start_fall && buf_in_ready);
        end
    end

    // data driven on select and read
    // full word, MSB on top line
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            done_oe_reg <= 1'b0;
            data_oe_reg <= 1'b0;
            data_reg    <= RESULT_RESET;
        end else begin
            done_oe_reg <= !done_output_enable_n;
            data_oe_reg <= !(chip_select_n || read_enable_n);
            if (read_start && buf_out_valid) begin
                data_reg <= buf_data;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            core_ready_reg <= 1'b0;
        end else begin
            core_ready_reg <= (state_reg != SACP_POWERUP) ||
                              (cnt_reg == CNT_W'(POWERUP_CYC - 1));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b || !track_reg) begin
            track_cnt_reg <= '0;
        end else if (track_cnt_reg != CNT_W'(TRACK_LEAD_CYC)) begin
            track_cnt_reg <= track_cnt_reg + 1'b1;
        end
    end

    assign done_out           = done_reg;
    assign done_oe            = done_oe_reg;
    assign result_bits.data   = data_reg;
    assign result_bits.oe     = data_oe_reg;
    assign track_mode         = track_reg;
    assign core_ready         = core_ready_reg;

    property p_busy;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == SACP_HOLD) |=> !done_reg;
    endproperty
    busy_done_low_a: assert property (p_busy) else $error("Done high while converting");

    ignore_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_reg == SACP_TRACK && cnt_reg != CNT_W'(CONV_CYC - 1))
        |=> state_reg == SACP_TRACK) else $error("Conversion cut short");

    start_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_reg == SACP_IDLE && start_fall && buf_in_ready)
        |=> state_reg == SACP_HOLD ##1 !track_reg) else $error("Start missed");

    track_back_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(state_reg == SACP_TRACK) |-> ##[1:2] track_reg) else $error("No track");

    track_lead_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(track_reg) |-> $past(track_cnt_reg) == CNT_W'(TRACK_LEAD_CYC))
        else $error("Track time too short");

    done_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        done_oe_reg == !$past(done_output_enable_n)) else $error("Done gate wrong");

    data_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(chip_select_n) |-> !data_oe_reg) else $error("Data driven unselected");

    done_rise_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_reg == SACP_TRACK && cnt_reg == CNT_W'(CONV_CYC - 1))
        |=> done_reg) else $error("Done not raised");

    idle_done_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_reg == SACP_IDLE) |-> done_reg) else $error("Idle done low");
endmodule
`default_nettype wire

// ---- tb/sacp_host.sv ----
// Host bus model that starts conversions and reads results
`timescale 1ns/100ps
`default_nettype none
module sacp_host
    import sacp_pkg::*;
(
    input  wire logic                core_clk,
    input  wire sacp_pkg::sacp_bus_t result_bits,
    output var  logic                start_convert_n,
    output var  logic                chip_select_n,
    output var  logic                read_enable_n
);
    initial begin
        start_convert_n = 1'b1;
        chip_select_n   = 1'b1;
        read_enable_n   = 1'b1;
    end
    task pulse_start();
        @(posedge core_clk) start_convert_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        start_convert_n <= 1'b1;
    endtask
    task read_word(input bit sel, output logic [13:0] d, output logic o);
        @(posedge core_clk) chip_select_n <= !sel;
        @(posedge core_clk) read_enable_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        d = result_bits.data;
        o = result_bits.oe;
        @(posedge core_clk) read_enable_n <= 1'b1;
        chip_select_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/sacp_port_test.sv ----
// Self-checking bench for the conversion bus port
`timescale 1ns/100ps
`default_nettype none
module sacp_port_test;
    import sacp_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        start_convert_n;
    logic        chip_select_n;
    logic        read_enable_n;
    logic        done_output_enable_n = 1'b1;
    logic        bipolar_offset_strap = 1'b0;
    logic [13:0] sample_code = 14'h0000;
    logic        done_out;
    logic        done_oe;
    sacp_bus_t   result_bits;
    logic        track_mode;
    logic        core_ready;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    logic [13:0] codes [6];
    logic [13:0] rd;
    logic        o;

    sacp_port i_sacp_port (.core_clk(core_clk), .rst_b(rst_b),
        .start_convert_n(start_convert_n), .chip_select_n(chip_select_n),
        .read_enable_n(read_enable_n), .done_output_enable_n(done_output_enable_n),
        .bipolar_offset_strap(bipolar_offset_strap), .sample_code(sample_code),
        .done_out(done_out), .done_oe(done_oe), .result_bits(result_bits),
        .track_mode(track_mode), .core_ready(core_ready));
    sacp_host i_sacp_host (.core_clk(core_clk), .result_bits(result_bits),
        .start_convert_n(start_convert_n), .chip_select_n(chip_select_n),
        .read_enable_n(read_enable_n));

    initial forever #12.5 core_clk = ~core_clk;

    task complete_run();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task cmp_word(input logic [13:0] e, input logic [13:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task cmp_bit(input logic e, input logic g);
        cmp_word({13'h0000, e}, {13'h0000, g});
    endtask

    function automatic logic [13:0] exp_code(input logic [13:0] c, input logic bip);
        return bip ? {~c[13], c[12:0]} : c;
    endfunction

    task do_reset(input logic bip);
        @(posedge core_clk) rst_b <= 1'b0;
        bipolar_offset_strap <= bip;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        cmp_bit(1'b1, done_out);
        cmp_bit(1'b1, track_mode);
        cmp_bit(1'b0, result_bits.oe);
        i_sacp_host.pulse_start();
        repeat (380) @(posedge core_clk);
        #1;
        cmp_bit(1'b0, core_ready);
        for (n = 0; n < 40 && core_ready !== 1'b1; n++) begin @(posedge core_clk); #1; end
        cmp_bit(1'b1, core_ready);
        cmp_bit(1'b1, done_out);
    endtask

    task convert(input logic [13:0] code, input bit again);
        @(posedge core_clk) sample_code <= code;
        i_sacp_host.pulse_start();
        #1;
        cmp_bit(1'b0, done_out);
        cmp_bit(1'b0, track_mode);
        @(posedge core_clk) sample_code <= 14'($urandom);
        repeat (HOLD_CYC - 4) @(posedge core_clk);
        #1;
        cmp_bit(1'b0, track_mode);
        @(posedge core_clk);
        #1;
        cmp_bit(1'b1, track_mode);
        cmp_bit(1'b0, done_out);
        if (again) begin i_sacp_host.pulse_start(); #1; end
        for (n = 0; n < 400 && done_out !== 1'b1; n++) begin @(posedge core_clk); #1; end
        cmp_bit(1'b1, done_out);
        cmp_word(14'(CONV_CYC - HOLD_CYC - (again ? 4 : 0)), 14'(n));
    endtask

    initial begin
        void'($urandom(10));
        codes = '{14'h1fff, 14'h2000, 14'h0000, 14'h3fff, 14'h0000, 14'h0000};
        for (int b = 0; b < 2; b++) begin
            do_reset(b[0]);
            codes[4] = 14'($urandom);
            codes[5] = 14'($urandom);
            for (int e = 0; e < 2; e++) begin
                @(posedge core_clk) done_output_enable_n <= e[0];
                repeat (3) @(posedge core_clk);
                #1;
                cmp_bit(!e[0], done_oe);
            end
            i_sacp_host.read_word(1'b0, rd, o);
            cmp_bit(1'b0, o);
            for (int i = 0; i < 6; i += 2) begin
                convert(codes[i], 1'b1);
                convert(codes[i+1], 1'b0);
                i_sacp_host.pulse_start();
                #1;
                cmp_bit(1'b1, done_out);
                for (int k = 0; k < 2; k++) begin
                    i_sacp_host.read_word(1'b1, rd, o);
                    cmp_bit(1'b1, o);
                    cmp_word(exp_code(codes[i+k], b[0]), rd);
                    #1;
                    cmp_bit(1'b0, result_bits.oe);
                end
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
